/* File: tss_top.sv */
// tone station selector: guard/group/station tone sequencing to a key output
// assumes tone codes, modem activity and modem bit come from an async detector
//
// Function
// - switch left reads one, right zero
// - switch one selects normal or test
// - switch eight is ignored
// - test bit latched at power-up, others live
// - identity is group plus tone, thirty
// - group on switches two-three, tone four-seven
// - test entered when switch one set
// - test keys while any tone is recognised
// - key output drives host busy request
// - demodulated modem bit to host data
// - no keying before guard tone in normal mode
// - identity match withholds next page batch
// - group tone keys without deselection
// - quarter second silence drops key
`timescale 1ns/1ps
module tss_top #(
	parameter int unsigned SILENCE_CYCLES = tss_pkg::SILENCE_CYCLES
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET,
	// configuration switch pins
	input wire logic [7:0] CONFIG_SWITCH,
	// tone detector and modem pins
	input wire logic [3:0] AUDIO_TONE,
	input wire logic AUDIO_ACTIVE,
	input wire logic AUDIO_MARK,
	// host board
	output logic KEY_OUTPUT,
	output logic DATA_OUTPUT,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic stn_valid(input logic [3:0] t);
		stn_valid = (t != tss_pkg::TONE_NONE) && (t <= tss_pkg::TONE_STN_MAX);
	endfunction

	function automatic logic is_group(input logic [3:0] t);
		is_group = (t >= tss_pkg::TONE_GRP1) && (t <= tss_pkg::TONE_GRP3);
	endfunction

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [7:0] sw_s1_q, sw_s2_q;
	logic [3:0] tn_s1_q, tn_s2_q, tn_s3_q;
	logic act_s1_q, act_s2_q, mk_s1_q, mk_s2_q;

	always_ff @(posedge REF_CLK) begin
		sw_s1_q <= CONFIG_SWITCH;
		sw_s2_q <= sw_s1_q;
		tn_s1_q <= AUDIO_TONE;
		tn_s2_q <= tn_s1_q;
		tn_s3_q <= tn_s2_q;
		act_s1_q <= AUDIO_ACTIVE;
		act_s2_q <= act_s1_q;
		mk_s1_q <= AUDIO_MARK;
		mk_s2_q <= mk_s1_q;
	end

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	tss_pkg::tss_cfg_s cfg;
	logic [3:0] tone_q, tone_d, prev_q;
	logic tone_evt, stn_match, grp_match;

	always_comb begin
		// lower switch number is the more significant bit, switch eight never looked at
		cfg.group = {sw_s2_q[tss_pkg::SW_GRP_HI], sw_s2_q[tss_pkg::SW_GRP_LO]};
		cfg.tone = {sw_s2_q[tss_pkg::SW_TONE_HI], sw_s2_q[tss_pkg::SW_TONE_HI + 1],
			sw_s2_q[tss_pkg::SW_TONE_LO - 1], sw_s2_q[tss_pkg::SW_TONE_LO]};
	end

	// code taken only when two samples agree
	assign tone_d = (tn_s2_q == tn_s3_q) ? tn_s2_q : tone_q;
	assign tone_evt = (tone_q != prev_q) && (tone_q != tss_pkg::TONE_NONE);
	// group and tone together name one of thirty stations
	assign stn_match = (cfg.group != tss_pkg::GRP_NONE) && stn_valid(tone_q)
		&& (stn_valid(cfg.tone) || cfg.tone == tss_pkg::TONE_ANY)
		&& (cfg.tone == tone_q || cfg.tone == tss_pkg::TONE_ANY);
	assign grp_match = (tone_q - tss_pkg::TONE_GRP1) == {2'h0, cfg.group - 2'h1};

	// ----------------------------------------
	// power-up strap capture
	// ----------------------------------------
	logic [1:0] strap_q, strap_d;
	logic test_q, test_d;

	always_comb begin
		strap_d = strap_q;
		test_d = test_q;
		if (strap_q != tss_pkg::STRAP_DONE) begin
			strap_d = strap_q + 2'h1;
			if (strap_q == 2'h2) begin
				test_d = sw_s2_q[tss_pkg::SW_TEST];
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			strap_q <= 2'h0;
			test_q <= 1'b0;
		end else begin
			strap_q <= strap_d;
			test_q <= test_d;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	tss_pkg::tss_state_e state_q, state_d;
	logic [tss_pkg::SIL_W-1:0] sil_q, sil_d;
	logic desel_q, desel_d, key_q, key_d, data_q, guard_q, guard_d, quiet, sil_end;
	logic [31:0] ctrl_q, ctrl_d;

	assign quiet = (tone_q == tss_pkg::TONE_NONE) && !act_s2_q;
	assign sil_end = sil_q == tss_pkg::SIL_W'(SILENCE_CYCLES - 1);

	always_comb begin
		state_d = state_q;
		desel_d = desel_q;
		guard_d = guard_q;
		sil_d = quiet ? sil_q + tss_pkg::SIL_W'(1) : '0;
		case (state_q)
			tss_pkg::ST_IDLE: begin
				sil_d = '0;
				desel_d = 1'b0;
				guard_d = 1'b0;
				if (strap_q == tss_pkg::STRAP_DONE && test_q) begin
					state_d = tss_pkg::ST_TESTM;
				end else if (strap_q == tss_pkg::STRAP_DONE && tone_q == tss_pkg::TONE_GUARD) begin
					state_d = tss_pkg::ST_ARMED;
					guard_d = 1'b1;
				end
			end
			tss_pkg::ST_ARMED: begin
				if (tone_evt && stn_match) begin
					desel_d = 1'b1;
				end
				if (tone_evt && is_group(tone_q)) begin
					state_d = (desel_q && grp_match) ? tss_pkg::ST_DSEL : tss_pkg::ST_KEYED;
				end
			end
			tss_pkg::ST_KEYED, tss_pkg::ST_DSEL: begin
				if (tone_evt && tone_q == tss_pkg::TONE_GUARD) begin
					state_d = tss_pkg::ST_ARMED;
					desel_d = 1'b0;
				end
			end
			tss_pkg::ST_TESTM: begin
				sil_d = '0;
			end
			default: begin
				state_d = tss_pkg::ST_IDLE;
			end
		endcase
		if (state_q != tss_pkg::ST_IDLE && state_q != tss_pkg::ST_TESTM && quiet && sil_end) begin
			state_d = tss_pkg::ST_IDLE;
			sil_d = '0;
		end
		if (state_d == tss_pkg::ST_TESTM) begin
			key_d = tone_d != tss_pkg::TONE_NONE;
		end else begin
			key_d = (state_d == tss_pkg::ST_KEYED) && !ctrl_q[tss_pkg::CTRL_INHIBIT];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			state_q <= tss_pkg::ST_IDLE;
			sil_q <= '0;
			desel_q <= 1'b0;
			guard_q <= 1'b0;
			key_q <= 1'b0;
			data_q <= 1'b0;
			tone_q <= tss_pkg::TONE_NONE;
			prev_q <= tss_pkg::TONE_NONE;
		end else begin
			state_q <= state_d;
			sil_q <= sil_d;
			desel_q <= desel_d;
			guard_q <= guard_d;
			key_q <= key_d;
			data_q <= mk_s2_q;
			tone_q <= tone_d;
			prev_q <= tone_q;
		end
	end

	assign KEY_OUTPUT = key_q;
	assign DATA_OUTPUT = data_q;

	// ----------------------------------------
	// apb registers
	// ----------------------------------------
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d, mapped;

	assign mapped = PADDR == tss_pkg::REG_CTRL || PADDR == tss_pkg::REG_STATUS
		|| PADDR == tss_pkg::REG_SWITCH;

	always_comb begin
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		err_d = err_q;
		if (PSEL && !PENABLE) begin
			err_d = !mapped;
			rdata_d = 32'h0000_0000;
			if (PADDR == tss_pkg::REG_CTRL) begin
				rdata_d = ctrl_q;
			end else if (PADDR == tss_pkg::REG_STATUS) begin
				rdata_d[tss_pkg::ST_KEY] = key_q;
				rdata_d[tss_pkg::ST_TEST] = test_q;
				rdata_d[tss_pkg::ST_DESEL] = desel_q;
				rdata_d[tss_pkg::ST_TONE_LO +: 4] = tone_q;
				rdata_d[tss_pkg::ST_STATE_LO +: 5] = state_q;
			end else if (PADDR == tss_pkg::REG_SWITCH) begin
				rdata_d[6:0] = sw_s2_q[6:0];
			end
		end
		if (PSEL && PENABLE && PWRITE && PADDR == tss_pkg::REG_CTRL) begin
			ctrl_d = {31'h0000_0000, PWDATA[tss_pkg::CTRL_INHIBIT]};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ctrl_q <= tss_pkg::CTRL_RESET;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	assign PREADY = 1'b1;
	assign PRDATA = rdata_q;
	assign PSLVERR = err_q && PSEL && PENABLE;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_test_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
		strap_q == tss_pkg::STRAP_DONE |=> $stable(test_q))
		else $error("test mode changed after power-up");

	chk_guard_first: assert property (@(posedge REF_CLK) disable iff (RESET)
		$rose(KEY_OUTPUT) && !test_q |-> guard_q)
		else $error("key raised without guard tone");

	chk_desel_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
		state_q == tss_pkg::ST_DSEL |-> !KEY_OUTPUT)
		else $error("key asserted while deselected");

	chk_group_keys: assert property (@(posedge REF_CLK) disable iff (RESET)
		state_q == tss_pkg::ST_ARMED && tone_evt && is_group(tone_q) && !desel_q && !quiet
		&& !ctrl_q[tss_pkg::CTRL_INHIBIT] |=> KEY_OUTPUT)
		else $error("group tone did not key");

	chk_silence_drop: assert property (@(posedge REF_CLK) disable iff (RESET)
		state_q == tss_pkg::ST_KEYED && quiet && sil_end |=> !KEY_OUTPUT && state_q == tss_pkg::ST_IDLE)
		else $error("key not dropped after silence");

	chk_test_key: assert property (@(posedge REF_CLK) disable iff (RESET)
		state_q == tss_pkg::ST_TESTM && $past(state_q) == tss_pkg::ST_TESTM
		|-> KEY_OUTPUT == (tone_q != tss_pkg::TONE_NONE))
		else $error("test key does not follow tone");

	chk_data_follow: assert property (@(posedge REF_CLK) disable iff (RESET)
		!$past(RESET) |-> DATA_OUTPUT == $past(mk_s2_q))
		else $error("data output does not follow modem bit");

	chk_bad_tone: assert property (@(posedge REF_CLK) disable iff (RESET)
		!stn_valid(cfg.tone) && cfg.tone != tss_pkg::TONE_ANY |-> !stn_match)
		else $error("invalid tone code matched");

	chk_no_test_key: assert property (@(posedge REF_CLK) disable iff (RESET)
		!test_q && strap_q == tss_pkg::STRAP_DONE |-> state_q != tss_pkg::ST_TESTM)
		else $error("test state without test strap");

endmodule

/* File: tss_pkg.sv */
// shared constants and types for the tone station selector
// assumes a 50 MHz REF_CLK and a tone detector that presents one tone code
package tss_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned SILENCE_MS = 250;
	localparam int unsigned SILENCE_CYCLES = SILENCE_MS * (CLK_HZ / 1000);
	localparam int unsigned SIL_W = 24;

	// ----------------------------------------
	// detected tone codes
	// ----------------------------------------
	localparam logic [3:0] TONE_NONE = 4'h0;
	localparam logic [3:0] TONE_STN_MAX = 4'hA;
	localparam logic [3:0] TONE_GUARD = 4'hB;
	localparam logic [3:0] TONE_GRP1 = 4'hC;
	localparam logic [3:0] TONE_GRP3 = 4'hE;
	localparam logic [3:0] TONE_ANY = 4'hF;

	// ----------------------------------------
	// switch fields (bit n is switch n+1)
	// ----------------------------------------
	localparam int SW_TEST = 0;
	localparam int SW_GRP_HI = 1;
	localparam int SW_GRP_LO = 2;
	localparam int SW_TONE_HI = 3;
	localparam int SW_TONE_LO = 6;
	localparam int SW_UNUSED = 7;
	localparam logic [1:0] GRP_NONE = 2'h0;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_SWITCH = 12'h008;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int CTRL_INHIBIT = 0;
	localparam int ST_KEY = 0;
	localparam int ST_TEST = 1;
	localparam int ST_DESEL = 2;
	localparam int ST_TONE_LO = 4;
	localparam int ST_STATE_LO = 8;
	localparam logic [1:0] STRAP_DONE = 2'h3;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_KEYED = 5'h04,
		ST_DSEL = 5'h08,
		ST_TESTM = 5'h10
	} tss_state_e;

	typedef struct packed {
		logic [1:0] group;
		logic [3:0] tone;
	} tss_cfg_s;

endpackage

/* File: tss_host_model.sv */
// host board and tone detector stand-in for the selector
// assumes the bench clock; the bench calls play and sets active/mark
`timescale 1ns/1ps
module tss_host_model (
	// clock and host side
	input wire logic clk,
	input wire logic key,
	// detector side
	output logic [3:0] tone,
	output logic active,
	output logic mark
);
	int pulses = 0;
	logic key_q = 1'h0;

	initial begin
		tone = 4'h0;
		active = 1'h0;
		mark = 1'h0;
	end

	// ----
	// busy request edges seen by the host
	// ----
	always @(posedge clk) begin
		key_q <= key;
		if (key === 1'h1 && key_q === 1'h0)
			pulses <= pulses + 1;
	end

	// one tone code held for n cycles
	task automatic play(input logic [3:0] c, input int n);
		@(posedge clk);
		tone <= c;
		repeat (n - 1) @(posedge clk);
	endtask

	// modem carrier present toward the selector
	task automatic set_active(input logic a);
		active <= a;
	endtask

	// demodulated modem bit toward the selector
	task automatic set_mark(input logic m);
		mark <= m;
	endtask
endmodule

/* File: tb_top.sv */
// self-checking bench for the tone station selector
// assumes a short silence count of 40 cycles and a 50 MHz clock
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, key, data, err;
	logic active, mark;
	logic [3:0] tone;
	logic [7:0] cfg;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int failures = 0;
	int samples_checked = 0;

	tss_top #(.SILENCE_CYCLES(40)) uut (.REF_CLK(ref_clk), .RESET(reset),
		.CONFIG_SWITCH(cfg), .AUDIO_TONE(tone), .AUDIO_ACTIVE(active),
		.AUDIO_MARK(mark), .KEY_OUTPUT(key), .DATA_OUTPUT(data), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	tss_host_model host (.clk(ref_clk), .key(key), .tone(tone), .active(active),
		.mark(mark));

	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ----
	// shared tasks
	// ----
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [7:0] sw(input logic t, input logic [1:0] g,
		input logic [3:0] n);
		return {1'h0, n[0], n[1], n[2], n[3], g[0], g[1], t};
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic do_reset(input logic [7:0] c);
		cfg <= c;
		reset <= 1'h1;
		repeat (6) @(posedge ref_clk);
		reset <= 1'h0;
		repeat (6) @(posedge ref_clk);
	endtask

	// quiet, guard, optional station tone, group tone, then key state
	task automatic run(input logic [7:0] c, input logic [3:0] stn,
		input logic [3:0] grp, input logic e);
		cfg <= c;
		host.play(4'h0, 60);
		host.play(4'hB, 10);
		if (stn != 4'h0)
			host.play(stn, 10);
		host.play(grp, 10);
		chk("key", 32'(e), 32'(key));
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (10000) @(posedge ref_clk);
		failures++;
		finish_test();
	end

	// ----
	// scenarios
	// ----
	task automatic test_registers();
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'h1, 12'h000, 32'h1);
		apb(1'h0, 12'h000, 32'h0);
		chk("ctrl", 32'h1, rd);
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h0, 12'h008, 32'h0);
		chk("switch", 32'h14, rd);
		apb(1'h0, 12'h00C, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		chk("unmapped", 32'h0, rd);
	endtask

	task automatic test_data();
		for (int i = 0; i < 4; i++) begin
			host.set_mark(!i[0]);
			repeat (6) @(posedge ref_clk);
			chk("data", 32'(!i[0]), 32'(data));
		end
	endtask

	task automatic test_keying();
		host.play(4'hC, 10);
		chk("key no guard", 32'h0, 32'(key));
		run(sw(1'h0, 2'h0, 4'h4), 4'h4, 4'hC, 1'h1);
		host.set_active(1'h1);
		host.play(4'h0, 30);
		chk("key active", 32'h1, 32'(key));
		host.set_active(1'h0);
		host.play(4'h0, 30);
		chk("key quiet", 32'h1, 32'(key));
		host.play(4'h0, 20);
		chk("key drop", 32'h0, 32'(key));
	endtask

	task automatic test_deselect();
		run(sw(1'h0, 2'h1, 4'h4), 4'h4, 4'hC, 1'h0);
		run(sw(1'h0, 2'h3, 4'hF), 4'h7, 4'hE, 1'h0);
		run(sw(1'h0, 2'h2, 4'hA), 4'hA, 4'hD, 1'h0);
		apb(1'h0, 12'h004, 32'h0);
		chk("status", 32'h0000_08D4, rd);
		run(sw(1'h0, 2'h2, 4'hA), 4'hA, 4'hC, 1'h1);
		run(sw(1'h0, 2'h1, 4'hC), 4'h4, 4'hC, 1'h1);
	endtask

	// key suppressed by the control bit, released once it clears
	task automatic test_inhibit();
		apb(1'h1, 12'h000, 32'h1);
		run(sw(1'h0, 2'h0, 4'h4), 4'h0, 4'hC, 1'h0);
		apb(1'h1, 12'h000, 32'h0);
		repeat (2) @(posedge ref_clk);
		chk("key released", 32'h1, 32'(key));
	endtask

	task automatic test_sweep();
		int n0;
		host.play(4'h0, 10);
		n0 = host.pulses;
		cfg <= sw(1'h0, 2'h0, 4'h0);
		for (int i = 0; i < 14; i++) begin
			host.play(4'(i < 4 ? 11 + i : 14 - i), 10);
			host.play(4'h0, 10);
		end
		chk("pulses", 32'h0000_000E, 32'(host.pulses - n0));
		apb(1'h0, 12'h004, 32'h0);
		chk("test bit", 32'h1, 32'(rd[1]));
	endtask

	initial begin
		reset = 1'h1;
		{psel, penable, pwrite, paddr, pwdata, cfg} = '0;
		do_reset(8'h94);
		chk("key idle", 32'h0, 32'(key));
		chk("data idle", 32'h0, 32'(data));
		test_registers();
		test_data();
		test_keying();
		test_deselect();
		test_inhibit();
		do_reset(sw(1'h1, 2'h0, 4'h0));
		test_sweep();
		finish_test();
	end
endmodule
